// File: inc/epmux_cfg.svh
`ifndef EPMUX_CFG_SVH
`define EPMUX_CFG_SVH

`define EPMUX_OFF_SEL     8'h00
`define EPMUX_OFF_OEN     8'h04
`define EPMUX_OFF_PE      8'h08
`define EPMUX_OFF_IEN     8'h0c
`define EPMUX_OFF_INLVL   8'h10
`define EPMUX_OFF_LATCH   8'h14
`define EPMUX_OFF_SET     8'h18
`define EPMUX_OFF_CLR     8'h1c
`define EPMUX_OFF_INV     8'h20
`define EPMUX_OFF_EVCFG   8'h24
`define EPMUX_OFF_EVFLAG  8'h28
`define EPMUX_OFF_EVCLR   8'h2c
`define EPMUX_OFF_SYNC    8'h30

`define EPMUX_RST_SEL     16'h0000
`define EPMUX_RST_PIN8    8'h00
`define EPMUX_RST_EVCFG   32'h0000_0000
`define EPMUX_RST_TRIG    4'h0

`define EPMUX_SEL_W       2
`define EPMUX_EVCFG_W     4
`define EPMUX_EV_EN_BIT   3
`define EPMUX_HSIZE_WORD  3'h2

`define EPMUX_EV_RISE     3'h0
`define EPMUX_EV_FALL     3'h1
`define EPMUX_EV_BOTH     3'h2
`define EPMUX_EV_HIGH     3'h3
`define EPMUX_EV_LOW      3'h4
`define EPMUX_EV_FALL2    3'h5
`define EPMUX_EV_BOTH2    3'h6
`define EPMUX_EV_HIGH2    3'h7

`endif

// File: inc/epmux_pkg.sv
package epmux_pkg;

    typedef logic [7:0] epmux_pins_t;

    typedef enum logic [2:0] {
        EPMUX_FN_GPIO  = 3'h0,
        EPMUX_FN_TRIG  = 3'h1,
        EPMUX_FN_SYNC  = 3'h3,
        EPMUX_FN_IRQ0  = 3'h2,
        EPMUX_FN_IRQ1  = 3'h6,
        EPMUX_FN_POR   = 3'h7,
        EPMUX_FN_SLEEP = 3'h5,
        EPMUX_FN_CLKIN = 3'h4
    } epmux_func_t;

endpackage

// File: inc/epmux_mux_if.sv
`timescale 1ns/1ps
interface epmux_mux_if;
    logic [15:0] sel;
    logic [7:0]  latch;
    logic [7:0]  sync;
    logic [1:0]  irq;
    logic        por;
    logic        sleep;
    logic [7:0]  in_s;
    logic [7:0]  drive;
    logic [7:0]  trig;
    logic        clk_in;

    modport ctl (output sel, latch, sync, irq, por, sleep, in_s,
                 input  drive, trig, clk_in);
    modport mux (input  sel, latch, sync, irq, por, sleep, in_s,
                 output drive, trig, clk_in);
endinterface

// File: src/epmux_sync.sv
`timescale 1ns/1ps
module epmux_sync #(
    parameter int W = 8
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // epmux_sync

// File: src/epmux_pin_mux.sv
`timescale 1ns/1ps
`include "epmux_cfg.svh"
module epmux_pin_mux
    import epmux_pkg::*;
(
    epmux_mux_if.mux m
);
    function automatic epmux_func_t decode(input int pin,
                                           input logic [1:0] code);
        epmux_func_t f;
        f = EPMUX_FN_GPIO;
        unique case (code)
            2'h1: f = EPMUX_FN_TRIG;
            2'h2: f = EPMUX_FN_SYNC;
            2'h0: begin
                if (pin == 0) f = EPMUX_FN_IRQ0;
                else if (pin == 2) f = EPMUX_FN_POR;
                else f = EPMUX_FN_GPIO;
            end
            2'h3: begin
                unique case (pin)
                    0: f = EPMUX_FN_GPIO;
                    1: f = EPMUX_FN_SLEEP;
                    2, 5: f = EPMUX_FN_CLKIN;
                    3, 6: f = EPMUX_FN_IRQ0;
                    default: f = EPMUX_FN_IRQ1;
                endcase
            end
        endcase
        return f;
    endfunction

    epmux_func_t fn [8];

    always_comb begin
        m.clk_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
            fn[i] = decode(i, m.sel[i*`EPMUX_SEL_W +: `EPMUX_SEL_W]);
            m.trig[i] = (fn[i] == EPMUX_FN_TRIG);
            if (fn[i] == EPMUX_FN_CLKIN && m.in_s[i])
                m.clk_in = 1'b1;
            unique case (fn[i])
                EPMUX_FN_GPIO:  m.drive[i] = m.latch[i];
                EPMUX_FN_SYNC:  m.drive[i] = m.sync[i];
                EPMUX_FN_IRQ0:  m.drive[i] = m.irq[0];
                EPMUX_FN_IRQ1:  m.drive[i] = m.irq[1];
                EPMUX_FN_POR:   m.drive[i] = m.por;
                EPMUX_FN_SLEEP: m.drive[i] = m.sleep;
                default:        m.drive[i] = 1'b0;
            endcase
        end
    end
endmodule // epmux_pin_mux

// File: src/epmux_top.sv
`timescale 1ns/1ps
`include "epmux_cfg.svh"
module epmux_top
    import epmux_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    output logic      [7:0]  pull_en,
    input  wire logic [1:0]  irq_line,
    input  wire logic        por_flag,
    input  wire logic        sleep_flag,
    input  wire logic        seq_sync_we,
    input  wire logic [7:0]  seq_sync_wdata,
    output logic      [3:0]  seq_trigger,
    output logic             wake_request,
    output logic             external_clock_in
);

    // bus address phase

    logic        addr_take;
    logic        rd_take;
    logic        wr_take;
    logic [7:0]  addr_b;

    assign addr_b    = haddr[7:0];
    // only whole-word transfers are acted on; others complete silently
    assign addr_take = hsel & hready & htrans[1]
                     & (hsize == `EPMUX_HSIZE_WORD);
    assign rd_take   = addr_take & ~hwrite;
    assign wr_take   = addr_take & hwrite;

    // data phase of a write

    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_take;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr_q <= 8'h00;
        end else begin
            wr_addr_q <= wr_take ? addr_b : wr_addr_q;
        end
    end

    // arguments passed explicitly so continuous assigns stay sensitive
    function automatic logic hit_at(input logic       pend,
                                    input logic [7:0] addr,
                                    input logic [7:0] off);
        return pend & (addr == off);
    endfunction

    logic        wr_sel;
    logic        wr_oen;
    logic        wr_pe;
    logic        wr_ien;
    logic        wr_latch;
    logic        wr_set;
    logic        wr_clr;
    logic        wr_inv;
    logic        wr_evcfg;
    logic        wr_evclr;
    logic [7:0]  wd8;

    assign wd8      = hwdata[7:0];
    assign wr_sel   = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_SEL);
    assign wr_oen   = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_OEN);
    assign wr_pe    = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_PE);
    assign wr_ien   = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_IEN);
    assign wr_latch = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_LATCH);
    assign wr_set   = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_SET);
    assign wr_clr   = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_CLR);
    assign wr_inv   = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_INV);
    assign wr_evcfg = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_EVCFG);
    assign wr_evclr = hit_at(wr_pend_q, wr_addr_q, `EPMUX_OFF_EVCLR);

    // port registers

    logic [15:0] sel_q;
    logic [7:0]  oen_q;
    logic [7:0]  pe_q;
    logic [7:0]  ien_q;
    logic [7:0]  latch_q;
    logic [7:0]  latch_d;

    // the four latch writers sit at distinct offsets, so at most one
    // of them is active in a cycle and the order below is immaterial
    assign latch_d = wr_latch ? wd8
                   : wr_set   ? (latch_q | wd8)
                   : wr_clr   ? (latch_q & ~wd8)
                   : wr_inv   ? (latch_q ^ wd8)
                   : latch_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= `EPMUX_RST_SEL;
        end else begin
            sel_q <= wr_sel ? hwdata[15:0] : sel_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oen_q <= `EPMUX_RST_PIN8;
        end else begin
            oen_q <= wr_oen ? wd8 : oen_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pe_q <= `EPMUX_RST_PIN8;
        end else begin
            pe_q <= wr_pe ? wd8 : pe_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ien_q <= `EPMUX_RST_PIN8;
        end else begin
            ien_q <= wr_ien ? wd8 : ien_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_q <= `EPMUX_RST_PIN8;
        end else begin
            latch_q <= latch_d;
        end
    end

    // pin input path

    logic [7:0]  in_s;
    logic [7:0]  prev_q;
    logic [7:0]  inlvl_q;
    logic [7:0]  inlvl_d;

    epmux_sync #(
        .W (8)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (pin_in),
        .q       (in_s)
    );

    // disabled pins hold their last captured level
    assign inlvl_d = (in_s & ien_q) | (inlvl_q & ~ien_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inlvl_q <= `EPMUX_RST_PIN8;
        end else begin
            inlvl_q <= inlvl_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= `EPMUX_RST_PIN8;
        end else begin
            prev_q <= in_s;
        end
    end

    // event detection

    logic [31:0] evcfg_q;
    logic [7:0]  evflag_q;
    logic [7:0]  evflag_d;
    logic [7:0]  ev_hit;
    logic [7:0]  ev_clr;

    function automatic logic event_hit(input logic [2:0] mode,
                                       input logic       cur,
                                       input logic       prv);
        logic h;
        h = 1'b0;
        unique case (mode)
            `EPMUX_EV_RISE:  h = cur & ~prv;
            `EPMUX_EV_FALL,
            `EPMUX_EV_FALL2: h = ~cur & prv;
            `EPMUX_EV_BOTH,
            `EPMUX_EV_BOTH2: h = cur ^ prv;
            `EPMUX_EV_HIGH,
            `EPMUX_EV_HIGH2: h = cur;
            `EPMUX_EV_LOW:   h = ~cur;
        endcase
        return h;
    endfunction

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ev_hit[i] = evcfg_q[i*`EPMUX_EVCFG_W + `EPMUX_EV_EN_BIT]
                      & event_hit(evcfg_q[i*`EPMUX_EVCFG_W +: 3],
                                  in_s[i], prev_q[i]);
        end
    end

    assign ev_clr   = wr_evclr ? wd8 : 8'h00;
    // a fresh event outranks a clear landing in the same cycle
    assign evflag_d = (evflag_q & ~ev_clr) | ev_hit;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evcfg_q <= `EPMUX_RST_EVCFG;
        end else begin
            evcfg_q <= wr_evcfg ? hwdata : evcfg_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evflag_q <= `EPMUX_RST_PIN8;
        end else begin
            evflag_q <= evflag_d;
        end
    end

    // sequencer sync register

    logic [7:0]  sync_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_q <= `EPMUX_RST_PIN8;
        end else begin
            sync_q <= seq_sync_we ? seq_sync_wdata : sync_q;
        end
    end

    // pin multiplex

    epmux_mux_if mx ();

    assign mx.sel   = sel_q;
    assign mx.latch = latch_q;
    assign mx.sync  = sync_q;
    assign mx.irq   = irq_line;
    assign mx.por   = por_flag;
    assign mx.sleep = sleep_flag;
    assign mx.in_s  = in_s;

    epmux_pin_mux u_mux (
        .m (mx.mux)
    );

    // sequence triggers: pins k and k+4 share trigger line k
    logic [3:0]  trig_d;
    logic [7:0]  trig_hit;
    logic [3:0]  trig_q;
    logic [7:0]  out_q;
    logic        clk_in_q;

    assign trig_hit = ev_hit & mx.trig;
    assign trig_d   = trig_hit[3:0] | trig_hit[7:4];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_q <= `EPMUX_RST_TRIG;
        end else begin
            trig_q <= trig_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_q <= `EPMUX_RST_PIN8;
        end else begin
            out_q <= mx.drive;
        end
    end

    // registered so the pin-derived clock leaves on a clean edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_in_q <= 1'b0;
        end else begin
            clk_in_q <= mx.clk_in;
        end
    end

    // the sequencer only reaches a pin if software set oen and selected the sync function in sel
    assign pin_out           = out_q;
    assign pin_oe            = oen_q;
    assign pull_en           = pe_q;
    assign seq_trigger       = trig_q;
    assign wake_request      = |evflag_q;
    assign external_clock_in = clk_in_q;

    // read path: data is captured in the address phase, so the
    // value seen is the state at that edge

    logic [31:0] rd_mux;
    logic [31:0] hrdata_q;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_b)
            `EPMUX_OFF_SEL:    rd_mux = {16'h0000, sel_q};
            `EPMUX_OFF_OEN:    rd_mux = {24'h00_0000, oen_q};
            `EPMUX_OFF_PE:     rd_mux = {24'h00_0000, pe_q};
            `EPMUX_OFF_IEN:    rd_mux = {24'h00_0000, ien_q};
            `EPMUX_OFF_INLVL:  rd_mux = {24'h00_0000, inlvl_q};
            `EPMUX_OFF_LATCH:  rd_mux = {24'h00_0000, latch_q};
            `EPMUX_OFF_EVCFG:  rd_mux = evcfg_q;
            `EPMUX_OFF_EVFLAG: rd_mux = {24'h00_0000, evflag_q};
            `EPMUX_OFF_SYNC:   rd_mux = {24'h00_0000, sync_q};
            // set, clear, invert and event clear read as zero
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else begin
            hrdata_q <= rd_take ? rd_mux : hrdata_q;
        end
    end

    // zero wait states; every transfer, mapped or not, ends OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

endmodule // epmux_top

// File: tb/epmux_asserts.sv
`timescale 1ns/1ps
module epmux_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic        hready,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  pull_en,
    input wire logic [1:0]  irq_line,
    input wire logic        seq_sync_we,
    input wire logic [7:0]  seq_sync_wdata
);
    logic        wr_q;
    logic        rd_q;
    logic [7:0]  a_q;
    logic [7:0]  sync_q;
    logic [15:0] sel_q;
    wire         take = hsel && hready && htrans[1] && hsize == 3'h2;

    // shadow copies let pin checks follow the selector without peeking inside
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            a_q    <= 8'h00;
            sync_q <= 8'h00;
            sel_q  <= 16'h0000;
        end else begin
            wr_q <= take && hwrite;
            rd_q <= take && !hwrite;
            if (take) a_q <= haddr[7:0];
            if (seq_sync_we) sync_q <= seq_sync_wdata;
            if (wr_q && a_q == 8'h00) sel_q <= hwdata[15:0];
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_wr(logic [7:0] a);
        wr_q && a_q == a;
    endsequence
    sequence s_rd_wo;
        rd_q && a_q inside {8'h18, 8'h1c, 8'h20};
    endsequence

    property p_oe;
        s_wr(8'h04) |=> pin_oe == $past(hwdata[7:0]);
    endproperty
    a_oe: assert property (p_oe) else $error("oe not loaded");
    property p_pe;
        s_wr(8'h08) |=> pull_en == $past(hwdata[7:0]);
    endproperty
    a_pe: assert property (p_pe) else $error("pull not loaded");
    property p_rst;
        $rose(hresetn) |-> pin_out == 8'h00 && pin_oe == 8'h00
            && pull_en == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("pins not idle");
    property p_wo;
        s_rd_wo |-> hrdata == 32'h0;
    endproperty
    a_wo: assert property (p_wo) else $error("wo read nonzero");
    property p_irq0;
        $past(hresetn) && $past(sel_q[1:0]) == 2'b00
            |-> pin_out[0] == $past(irq_line[0]);
    endproperty
    a_irq0: assert property (p_irq0) else $error("pin0 irq");
    property p_irq3;
        $past(hresetn) && $past(sel_q[7:6]) == 2'b11
            |-> pin_out[3] == $past(irq_line[0]);
    endproperty
    a_irq3: assert property (p_irq3) else $error("pin3 irq");
    property p_irq7;
        $past(hresetn) && $past(sel_q[15:14]) == 2'b11
            |-> pin_out[7] == $past(irq_line[1]);
    endproperty
    a_irq7: assert property (p_irq7) else $error("pin7 irq");
    property p_sync4;
        $past(hresetn) && $past(sel_q[9:8]) == 2'b10
            |-> pin_out[4] == $past(sync_q[4]);
    endproperty
    a_sync4: assert property (p_sync4) else $error("pin4 sync");
endmodule // epmux_asserts

bind epmux_top epmux_asserts u_asserts (
    .hclk, .hresetn, .hsel, .hready, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hreadyout, .hresp, .hrdata, .pin_out, .pin_oe, .pull_en,
    .irq_line, .seq_sync_we, .seq_sync_wdata
);

// File: tb/epmux_pin_model.sv
`timescale 1ns/1ps
module epmux_pin_model (
    input wire logic       hclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] mcu_en,
    input wire logic [7:0] mcu_val,
    output logic     [7:0] pin_in
);
    // a released pin with no pull wanders, so a stale level cannot pass
    logic [7:0] drift_q = 8'h55;
    wire  [7:0] host_drv = ~pin_oe & mcu_en;
    wire  [7:0] floating = ~pin_oe & ~mcu_en;

    always @(posedge hclk) drift_q <= ~drift_q;

    // host only drives pins the port has released
    assign pin_in = (pin_oe & pin_out) | (host_drv & mcu_val)
                  | (floating & (pull_en | drift_q));
endmodule // epmux_pin_model

// File: tb/eight_pin_port_with_mux_tb.sv
`timescale 1ns/1ps
module eight_pin_port_with_mux_tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        por_flag, sleep_flag, seq_sync_we, wake_request;
    logic        external_clock_in;
    logic        rd_dp = 1'b0;
    logic [1:0]  htrans, irq_line;
    logic [2:0]  hsize;
    logic [3:0]  seq_trigger;
    logic [7:0]  pin_in, pin_out, pin_oe, pull_en, seq_sync_wdata;
    logic [7:0]  mcu_en, mcu_val;
    logic [31:0] haddr, hwdata, hrdata, v, e;
    logic [31:0] exp_q[$];
    int          fail_count = 0;
    int          samples_checked = 0;
    string       fn[8] = '{"0TYG", "GTYS", "PTYC", "GTY0",
                           "GTY1", "GTYC", "GTY0", "GTY1"};

    epmux_top DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pin_in, .pin_out,
        .pin_oe, .pull_en, .irq_line, .por_flag, .sleep_flag, .seq_sync_we,
        .seq_sync_wdata, .seq_trigger, .wake_request, .external_clock_in
    );
    epmux_pin_model u_pins (
        .hclk, .pin_out, .pin_oe, .pull_en, .mcu_en, .mcu_val, .pin_in
    );

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic end_sim;
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] x);
        exp_q.push_back(x);
        xfer(1'b0, a, 32'h0);
    endtask

    // trigger and clock-in functions are inputs, so the pin shows 0
    function automatic logic pin_bit(int p, int c, logic [31:0] r);
        case (fn[p][c])
            "G": return r[16+p];
            "Y": return r[8+p];
            "0": return r[0];
            "1": return r[1];
            "P": return r[2];
            "S": return r[3];
            default: return 1'b0;
        endcase
    endfunction

    always @(posedge hclk) begin
        if (rd_dp) chk("hrdata", exp_q.pop_front(), hrdata);
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    initial begin
        #400_000;
        fail_count++;
        end_sim;
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        irq_line = 2'b00;
        por_flag = 1'b0;
        sleep_flag = 1'b0;
        seq_sync_we = 1'b0;
        seq_sync_wdata = 8'h00;
        mcu_en = 8'hff;
        mcu_val = 8'h00;
        v = $urandom(32'h5250);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
        v = $urandom;
        xfer(1'b1, 8'h04, {24'h0, v[7:0]});
        xfer(1'b1, 8'h08, {24'h0, v[15:8]});
        rd(8'h04, {24'h0, v[7:0]});
        rd(8'h08, {24'h0, v[15:8]});
        xfer(1'b1, 8'h04, 32'h0);
        mcu_val <= v[23:16];
        xfer(1'b1, 8'h0c, {24'h0, v[31:24]});
        repeat (4) @(posedge hclk);
        // the flip must not show yet: the level register lags the pins
        mcu_val <= ~v[23:16];
        rd(8'h10, {24'h0, v[23:16] & v[31:24]});
        mcu_val <= 8'h00;
        xfer(1'b1, 8'h24, 32'h8);
        repeat (3) @(posedge hclk);
        mcu_val <= 8'h01;
        repeat (6) @(posedge hclk);
        chk("wake_request", 32'h1, {31'h0, wake_request});
        rd(8'h28, 32'h1);
        xfer(1'b1, 8'h2c, 32'h1);
        xfer(1'b1, 8'h24, 32'h0);
        chk("wake_request", 32'h0, {31'h0, wake_request});
        v = $urandom;
        e = {24'h0, v[7:0]};
        xfer(1'b1, 8'h14, e);
        for (int i = 0; i < 3; i++) begin
            v = $urandom;
            xfer(1'b1, 8'h18 + 8'(4 * i), {24'h0, v[7:0]});
            if (i == 0) e[7:0] |= v[7:0];
            else if (i == 1) e[7:0] &= ~v[7:0];
            else e[7:0] ^= v[7:0];
            rd(8'h14, e);
        end
        for (int a = 24; a <= 32; a += 4) rd(8'(a), 32'h0);
        rd(8'h14, e);
        xfer(1'b1, 8'h04, 32'hff);
        for (int c = 0; c < 4; c++) begin
            v = $urandom;
            irq_line <= v[1:0];
            por_flag <= v[2];
            sleep_flag <= v[3];
            seq_sync_we <= 1'b1;
            seq_sync_wdata <= v[15:8];
            @(posedge hclk);
            seq_sync_we <= 1'b0;
            xfer(1'b1, 8'h00, {16'h0, {8{2'(c)}}});
            xfer(1'b1, 8'h14, {24'h0, v[23:16]});
            repeat (2) @(posedge hclk);
            e = 32'h0;
            for (int p = 0; p < 8; p++) e[p] = pin_bit(p, c, v);
            chk("pin_out", e, {24'h0, pin_out});
        end
        // host drives all pins; clock-in and trigger inputs
        xfer(1'b1, 8'h04, 32'h0);
        v = $urandom;
        mcu_val <= v[7:0];
        xfer(1'b1, 8'h00, 32'hffff);
        repeat (4) @(posedge hclk);
        chk("external_clock_in", {31'h0, v[2] | v[5]},
            {31'h0, external_clock_in});
        xfer(1'b1, 8'h00, 32'h5555);
        xfer(1'b1, 8'h24, 32'hb);
        repeat (4) @(posedge hclk);
        chk("seq_trigger", {31'h0, v[0]}, {28'h0, seq_trigger});
        chk("hresp", 32'h0, {31'h0, hresp});
        end_sim;
    end
endmodule // eight_pin_port_with_mux_tb
